// file: verilog/power_good_output_sequence_option_regs.sv
`default_nettype none
// How it works
// - Selector 00 gives limits -16.67, -12.5, -8.33, 12.50, 8.33, 16.67 percent.
// - Selector 01 gives limits -12.50, -8.33, -4.17, 8.33, 4.17, 12.50 percent.
// - Selector 10 gives low limits -29.17, -20.83, -16.67; high side as 01.
// - Selector 11 gives low limits -41.67, -37.50, -33.33; high side as 01.
// - Power good drops at low trip, returns only above low release.
// - Power good drops at high trip, returns only below high release.
// - Tripped overvoltage holds flag and power good low until below high release.
// - Tripped undervoltage holds flag and power good low until above low release.
// - Delay setting is paged; two-phase mode refuses writes to page one.
// - Delay byte: turn-on in 7:5, turn-off in 3:1, bits 4,0 read zero.
// - After enable, wait turn-on value times ramp time, then start soft-start.
// - After disable, keep switching turn-off value times ramp time, then stop.
// - Options word is 16 bits, bits 2:0 writable, default has 6,5,4,2 set.
// - Store-all command copies writable option bits into non-volatile memory.
// - Option bit 2 runs the monitoring converter; zero disables it.
// - Option bit 1 lengthens second channel gate-driver dead time.
// - Option bit 0 lengthens first channel gate-driver dead time.
// - Identification word is read-only: 12-bit identifier over 4-bit revision.
// - All limits are percentages of nominal reference against each feedback input.
// - Selector sits in bits 1:0 of a paged byte, upper bits zero, resets 00.
// - Two-phase mode refuses selector writes to page one.
module power_good_output_sequence_option_regs
  import pg_seq_pkg::*;
#(
  parameter int          FB_W        = 12,
  parameter int          CNT_W       = 16,
  parameter int          RAMP_CYCLES = RAMP_CYCLES_DEF,
  parameter logic [11:0] IDENT_CODE  = 12'h05a,  // Arbitrary value
  parameter logic [3:0]  REV_CODE    = 4'h1      // Arbitrary value
) (
  input  wire logic            i_mclk,
  input  wire logic            i_reset_n,
  input  wire logic            i_two_phase,
  input  wire logic [1:0]      i_output_enable,
  input  wire logic [FB_W-1:0] i_nominal_ref,
  input  wire logic [FB_W-1:0] i_feedback_input_0,
  input  wire logic [FB_W-1:0] i_feedback_input_1,
  input  wire logic            i_cmd_valid,
  input  wire logic            i_cmd_write,
  input  wire logic [7:0]      i_cmd_code,
  input  wire logic            i_cmd_page,
  input  wire logic [15:0]     i_cmd_wdata,
  output logic                 o_cmd_done,
  output logic                 o_cmd_ack,
  output logic [15:0]          o_cmd_rdata,
  output logic [1:0]           o_power_good_output,
  output logic [1:0]           o_low_output_fault,
  output logic [1:0]           o_high_output_fault,
  output logic [1:0]           o_soft_start_go,
  output logic [1:0]           o_switching,
  output logic                 o_monitor_converter_enable,
  output logic                 o_first_channel_deadtime_extend,
  output logic                 o_second_channel_deadtime_extend,
  output logic                 o_nvm_store,
  output logic [2:0]           o_nvm_options
);

  // ****************************************************************
  // Register storage
  // ****************************************************************
  logic [1:0]  sel_q [2];
  logic [7:0]  delay_q [2];
  logic [2:0]  opt_q;
  logic        done_q;
  logic        ack_q;
  logic [15:0] rdata_q;
  logic        nvm_store_q;
  logic [2:0]  nvm_opt_q;

  logic        page_ok;
  logic        wr_sel;
  logic        wr_delay;
  logic        wr_opt;
  logic        do_store;
  logic        ack_d;
  logic [15:0] rdata_d;
  logic [15:0] opt_word;
  logic [15:0] ident_word;

  assign page_ok    = !(i_two_phase && i_cmd_page);
  assign wr_sel     = i_cmd_valid && i_cmd_write && i_cmd_code == CMD_THRESH_SEL
                      && page_ok;
  assign wr_delay   = i_cmd_valid && i_cmd_write && i_cmd_code == CMD_ON_OFF_DLY
                      && page_ok;
  assign wr_opt     = i_cmd_valid && i_cmd_write && i_cmd_code == CMD_OPTIONS;
  assign do_store   = i_cmd_valid && i_cmd_write && i_cmd_code == CMD_STORE_ALL;
  assign opt_word   = (OPT_RESET & ~OPT_WR_MASK) | {13'h0000, opt_q};
  assign ident_word = {IDENT_CODE, REV_CODE};

  // ****************************************************************
  // Command decode
  // ****************************************************************
  always_comb begin
    ack_d   = 1'b0;
    rdata_d = 16'h0000;
    case (i_cmd_code)
      CMD_THRESH_SEL: begin
        ack_d   = !i_cmd_write || page_ok;
        rdata_d = {14'h0000, sel_q[i_cmd_page]};
      end
      CMD_ON_OFF_DLY: begin
        ack_d   = !i_cmd_write || page_ok;
        rdata_d = {8'h00, delay_q[i_cmd_page]};
      end
      CMD_OPTIONS: begin
        ack_d   = 1'b1;
        rdata_d = opt_word;
      end
      CMD_IDENT: begin
        ack_d   = !i_cmd_write;
        rdata_d = ident_word;
      end
      CMD_STORE_ALL: begin
        ack_d   = i_cmd_write;
      end
      default: begin
        ack_d   = 1'b0;
        rdata_d = 16'h0000;
      end
    endcase
  end

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      done_q  <= 1'b0;
      ack_q   <= 1'b0;
      rdata_q <= 16'h0000;
    end else begin
      done_q  <= i_cmd_valid;
      ack_q   <= i_cmd_valid && ack_d;
      rdata_q <= (i_cmd_valid && !i_cmd_write) ? rdata_d : 16'h0000;
    end
  end

  // ****************************************************************
  // Paged settings
  // ****************************************************************
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      sel_q[0] <= SEL_RESET;
      sel_q[1] <= SEL_RESET;
    end else if (wr_sel) begin
      sel_q[i_cmd_page] <= i_cmd_wdata[SEL_MSB:0];
    end
  end

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      delay_q[0] <= DELAY_RESET;
      delay_q[1] <= DELAY_RESET;
    end else if (wr_delay) begin
      delay_q[i_cmd_page] <= i_cmd_wdata[7:0] & DELAY_WR_MASK;
    end
  end

  // ****************************************************************
  // Options and store
  // ****************************************************************
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      opt_q <= OPT_RESET[OPT_WR_MSB:0];
    end else if (wr_opt) begin
      opt_q <= i_cmd_wdata[OPT_WR_MSB:0];
    end
  end

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      nvm_store_q <= 1'b0;
      nvm_opt_q   <= OPT_RESET[OPT_WR_MSB:0];
    end else begin
      nvm_store_q <= do_store;
      if (do_store) begin
        nvm_opt_q <= opt_q;
      end
    end
  end

  assign o_monitor_converter_enable       = opt_q[OPT_ADC_BIT];
  assign o_second_channel_deadtime_extend = opt_q[OPT_DT2_BIT];
  assign o_first_channel_deadtime_extend  = opt_q[OPT_DT1_BIT];
  assign o_nvm_store                      = nvm_store_q;
  assign o_nvm_options                    = nvm_opt_q;
  assign o_cmd_done                       = done_q;
  assign o_cmd_ack                        = ack_q;
  assign o_cmd_rdata                      = rdata_q;

  // ****************************************************************
  // Per-channel monitor and sequencer
  // ****************************************************************
  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++) begin : g_ch
      window_mon_if #(.FB_W(FB_W)) mon_bus ();
      seq_state_t       state_q;
      logic [CNT_W-1:0] cnt_q;
      logic [CNT_W-1:0] on_wait;
      logic [CNT_W-1:0] off_wait;
      logic             go_q;
      logic             sw_q;
      logic             src;

      assign src = (ch == 1) && !i_two_phase;
      assign mon_bus.sel     = sel_q[src];
      assign mon_bus.fb      = (ch == 0) ? i_feedback_input_0 : i_feedback_input_1;
      assign mon_bus.nominal = i_nominal_ref;
      assign on_wait  = CNT_W'(delay_q[src][TON_MSB:TON_LSB]) * CNT_W'(RAMP_CYCLES);
      assign off_wait = CNT_W'(delay_q[src][TOFF_MSB:TOFF_LSB]) * CNT_W'(RAMP_CYCLES);

      window_monitor #(
        .FB_W (FB_W)
      ) u_mon (
        .i_mclk    (i_mclk),
        .i_reset_n (i_reset_n),
        .mon       (mon_bus)
      );

      always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
          state_q <= SEQ_OFF;
          cnt_q   <= '0;
          go_q    <= 1'b0;
          sw_q    <= 1'b0;
        end else begin
          go_q <= 1'b0;
          case (state_q)
            SEQ_OFF: begin
              if (i_output_enable[ch]) begin
                if (on_wait == '0) begin
                  state_q <= SEQ_RUN;
                  go_q    <= 1'b1;
                  sw_q    <= 1'b1;
                end else begin
                  state_q <= SEQ_ON_WAIT;
                  cnt_q   <= on_wait - CNT_W'(1);
                end
              end
            end
            SEQ_ON_WAIT: begin
              if (!i_output_enable[ch]) begin
                state_q <= SEQ_OFF;
              end else if (cnt_q == '0) begin
                state_q <= SEQ_RUN;
                go_q    <= 1'b1;
                sw_q    <= 1'b1;
              end else begin
                cnt_q <= cnt_q - CNT_W'(1);
              end
            end
            SEQ_RUN: begin
              if (!i_output_enable[ch]) begin
                if (off_wait == '0) begin
                  state_q <= SEQ_OFF;
                  sw_q    <= 1'b0;
                end else begin
                  state_q <= SEQ_OFF_WAIT;
                  cnt_q   <= off_wait - CNT_W'(1);
                end
              end
            end
            SEQ_OFF_WAIT: begin
              if (i_output_enable[ch]) begin
                state_q <= SEQ_RUN;
              end else if (cnt_q == '0) begin
                state_q <= SEQ_OFF;
                sw_q    <= 1'b0;
              end else begin
                cnt_q <= cnt_q - CNT_W'(1);
              end
            end
            default: begin
              state_q <= SEQ_OFF;
              sw_q    <= 1'b0;
            end
          endcase
        end
      end

      assign o_soft_start_go[ch]     = go_q;
      assign o_switching[ch]         = sw_q;
      assign o_power_good_output[ch] = mon_bus.pg;
      assign o_low_output_fault[ch]  = mon_bus.uv;
      assign o_high_output_fault[ch] = mon_bus.ov;

      a_zero_delay_start: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
        state_q == SEQ_OFF && i_output_enable[ch] && on_wait == '0 |=> go_q && sw_q)
        else $error("Zero turn-on delay did not start at once");

      a_one_ramp_start: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
        state_q == SEQ_OFF && i_output_enable[ch] && on_wait == CNT_W'(RAMP_CYCLES)
        && RAMP_CYCLES == 2 ##1 i_output_enable[ch][*2] |-> !go_q ##1 go_q)
        else $error("Turn-on delay of one ramp mistimed");

      a_off_keeps_switch: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
        state_q == SEQ_RUN && !i_output_enable[ch] && off_wait != '0 |=> sw_q)
        else $error("Switching stopped before turn-off delay");
    end
  endgenerate

  // ****************************************************************
  // Checks
  // ****************************************************************
  a_page_one_refused: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    i_cmd_valid && i_cmd_write && i_two_phase && i_cmd_page
    && (i_cmd_code == CMD_ON_OFF_DLY || i_cmd_code == CMD_THRESH_SEL)
    |=> o_cmd_done && !o_cmd_ack && $stable(delay_q[1]) && $stable(sel_q[1]))
    else $error("Page one write taken in two-phase mode");

  a_delay_reserved: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    i_cmd_valid && !i_cmd_write && i_cmd_code == CMD_ON_OFF_DLY
    |=> o_cmd_rdata[4] == 1'b0 && o_cmd_rdata[0] == 1'b0 && o_cmd_rdata[15:8] == 8'h00)
    else $error("Reserved delay bits read nonzero");

  a_sel_upper_zero: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    i_cmd_valid && !i_cmd_write && i_cmd_code == CMD_THRESH_SEL
    |=> o_cmd_ack && o_cmd_rdata[15:2] == 14'h0000)
    else $error("Selector upper bits read nonzero");

  a_ident_fixed: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    i_cmd_valid && !i_cmd_write && i_cmd_code == CMD_IDENT
    |=> o_cmd_ack && o_cmd_rdata == {IDENT_CODE, REV_CODE})
    else $error("Identification word wrong");

  a_option_steer: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    wr_opt |=> o_monitor_converter_enable == $past(i_cmd_wdata[OPT_ADC_BIT])
    && o_second_channel_deadtime_extend == $past(i_cmd_wdata[OPT_DT2_BIT])
    && o_first_channel_deadtime_extend == $past(i_cmd_wdata[OPT_DT1_BIT]))
    else $error("Option bits did not steer outputs");

  a_option_fixed: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    i_cmd_valid && !i_cmd_write && i_cmd_code == CMD_OPTIONS
    |=> o_cmd_rdata[15:3] == OPT_RESET[15:3])
    else $error("Read-only option bits changed");

  a_store_copy: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    do_store |=> o_nvm_store && o_nvm_options == $past(opt_q))
    else $error("Store did not copy option bits");

endmodule : power_good_output_sequence_option_regs
`default_nettype wire

// file: verilog/pg_seq_pkg.sv
`default_nettype none
package pg_seq_pkg;

  // ****************************************************************
  // Command codes
  // ****************************************************************
  localparam logic [7:0] CMD_STORE_ALL   = 8'h15;
  localparam logic [7:0] CMD_THRESH_SEL  = 8'hd7;
  localparam logic [7:0] CMD_ON_OFF_DLY  = 8'hd8;
  localparam logic [7:0] CMD_OPTIONS     = 8'he5;
  localparam logic [7:0] CMD_IDENT       = 8'hfc;

  // ****************************************************************
  // Field layouts and reset values
  // ****************************************************************
  localparam int          SEL_MSB        = 1;
  localparam int          TON_MSB        = 7;
  localparam int          TON_LSB        = 5;
  localparam int          TOFF_MSB       = 3;
  localparam int          TOFF_LSB       = 1;
  localparam int          OPT_ADC_BIT    = 2;
  localparam int          OPT_DT2_BIT    = 1;
  localparam int          OPT_DT1_BIT    = 0;
  localparam int          OPT_WR_MSB     = 2;
  localparam logic [1:0]  SEL_RESET      = 2'h0;
  localparam logic [7:0]  DELAY_RESET    = 8'h00;
  localparam logic [7:0]  DELAY_WR_MASK  = 8'hee;
  localparam logic [15:0] OPT_RESET      = 16'h0074;
  localparam logic [15:0] OPT_WR_MASK    = 16'h0007;

  // ****************************************************************
  // Window limits, hundredths of a percent of nominal
  // ****************************************************************
  localparam int PCT_SCALE = 10000;
  localparam int UV_PCT [4]    = '{-1667, -1250, -2917, -4167};
  localparam int LTRIP_PCT [4] = '{-1250, -833, -2083, -3750};
  localparam int LREL_PCT [4]  = '{-833, -417, -1667, -3333};
  localparam int HTRIP_PCT [4] = '{1250, 833, 833, 833};
  localparam int HREL_PCT [4]  = '{833, 417, 417, 417};
  localparam int OV_PCT [4]    = '{1667, 1250, 1250, 1250};

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS   = 20;
  localparam int RAMP_TIME_NS    = 1000;
  localparam int RAMP_CYCLES_DEF = RAMP_TIME_NS / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    SEQ_OFF      = 2'h0,
    SEQ_ON_WAIT  = 2'h1,
    SEQ_RUN      = 2'h3,
    SEQ_OFF_WAIT = 2'h2
  } seq_state_t;

endpackage : pg_seq_pkg
`default_nettype wire

// file: verilog/window_mon_if.sv
`default_nettype none
interface window_mon_if #(
  parameter int FB_W = 12
);
  logic [1:0]      sel;
  logic [FB_W-1:0] fb;
  logic [FB_W-1:0] nominal;
  logic            pg;
  logic            uv;
  logic            ov;

  modport mon (input sel, input fb, input nominal, output pg, output uv, output ov);
  modport ctl (output sel, output fb, output nominal, input pg, input uv, input ov);
endinterface : window_mon_if
`default_nettype wire

// file: verilog/window_monitor.sv
`default_nettype none
module window_monitor
  import pg_seq_pkg::*;
#(
  parameter int FB_W = 12
) (
  input  wire logic       i_mclk,
  input  wire logic       i_reset_n,
  window_mon_if.mon       mon
);

  // ****************************************************************
  // Levels from selector
  // ****************************************************************
  int   lvl_uv, lvl_ltrip, lvl_lrel, lvl_htrip, lvl_hrel, lvl_ov;
  int   fb_i;
  logic uv_q, ov_q, ltrip_q, htrip_q, pg_q;
  logic uv_d, ov_d, ltrip_d, htrip_d;

  function automatic int level(input int nom, input int pct);
    level = (nom * (PCT_SCALE + pct)) / PCT_SCALE;
  endfunction : level

  always_comb begin
    fb_i      = int'(mon.fb);
    lvl_uv    = level(int'(mon.nominal), UV_PCT[mon.sel]);
    lvl_ltrip = level(int'(mon.nominal), LTRIP_PCT[mon.sel]);
    lvl_lrel  = level(int'(mon.nominal), LREL_PCT[mon.sel]);
    lvl_htrip = level(int'(mon.nominal), HTRIP_PCT[mon.sel]);
    lvl_hrel  = level(int'(mon.nominal), HREL_PCT[mon.sel]);
    lvl_ov    = level(int'(mon.nominal), OV_PCT[mon.sel]);
  end

  // ****************************************************************
  // Hysteretic trip latches
  // ****************************************************************
  always_comb begin
    ltrip_d = (fb_i <= lvl_ltrip) || (ltrip_q && fb_i <= lvl_lrel);
    htrip_d = (fb_i >= lvl_htrip) || (htrip_q && fb_i >= lvl_hrel);
    ov_d    = (fb_i >= lvl_ov) || (ov_q && fb_i >= lvl_hrel);
    uv_d    = (fb_i <= lvl_uv) || (uv_q && fb_i <= lvl_lrel);
  end

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ltrip_q <= 1'b0;
      htrip_q <= 1'b0;
      ov_q    <= 1'b0;
      uv_q    <= 1'b0;
      pg_q    <= 1'b0;
    end else begin
      ltrip_q <= ltrip_d;
      htrip_q <= htrip_d;
      ov_q    <= ov_d;
      uv_q    <= uv_d;
      pg_q    <= !(ltrip_d || htrip_d || ov_d || uv_d);
    end
  end

  assign mon.pg = pg_q;
  assign mon.uv = uv_q;
  assign mon.ov = ov_q;

  // ****************************************************************
  // Checks
  // ****************************************************************
  a_ov_hold_release: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    ov_q && fb_i >= lvl_hrel |=> ov_q && !pg_q)
    else $error("Overvoltage released above high release level");

  a_uv_hold_release: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    uv_q && fb_i <= lvl_lrel |=> uv_q && !pg_q)
    else $error("Undervoltage released below low release level");

  a_low_trip_drop: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    fb_i <= lvl_ltrip |=> !pg_q)
    else $error("Power good stayed high at low trip level");

  a_high_trip_drop: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    fb_i >= lvl_htrip |=> !pg_q)
    else $error("Power good stayed high at high trip level");

  a_pg_clean_window: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    $rose(pg_q) |-> !ov_q && !uv_q && $past(fb_i) > $past(lvl_ltrip))
    else $error("Power good rose with a fault latched");

endmodule : window_monitor
`default_nettype wire

// file: verification/pmbus_host_model.sv
`default_nettype none
// ****************************************
// Command issuer on the far side
// ****************************************
module pmbus_host_model (
  input  wire logic        i_mclk,
  output logic             o_valid,
  output logic             o_write,
  output logic [7:0]       o_code,
  output logic             o_page,
  output logic [15:0]      o_wdata
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    o_valid = 1'b0;
    o_write = 1'b0;
    o_code  = 8'h00;
    o_page  = 1'b0;
    o_wdata = 16'h0000;
  end
  task automatic send(input logic w, input logic [7:0] c, input logic p, input logic [15:0] d);
    @(posedge i_mclk);
    #1;
    o_valid = 1'b1;
    o_write = w;
    o_code  = c;
    o_page  = p;
    o_wdata = d;
    @(posedge i_mclk);
    #1;
    o_valid = 1'b0;
    o_wdata = ~d;
  endtask : send
endmodule : pmbus_host_model
`default_nettype wire

// file: verification/power_good_output_sequence_option_regs_tb.sv
`default_nettype none
// ****************************************
// Self-checking bench
// ****************************************
module power_good_output_sequence_option_regs_tb;
  import pg_seq_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int          RAMP = 2;
  localparam int          NOM  = 1200;
  localparam logic [11:0] ID   = 12'h3c1;  // Arbitrary value
  localparam logic [3:0]  REV  = 4'h2;     // Arbitrary value
  logic        clk, rst_n, two_ph, v, w, pg_sel, done, ack, nvm_st, mon_en, dt1, dt2;
  logic [1:0]  en, pg, uv, ov, go, sw;
  logic [11:0] fb0;
  logic [7:0]  code;
  logic [15:0] wd, rd;
  logic [2:0]  nvm_o;
  logic [16:0] exp_q[$];
  int          errors, tests_run, seed, k;
  pmbus_host_model i_host (.i_mclk(clk), .o_valid(v), .o_write(w), .o_code(code),
    .o_page(pg_sel), .o_wdata(wd));
  power_good_output_sequence_option_regs #(.RAMP_CYCLES(RAMP), .IDENT_CODE(ID), .REV_CODE(REV)) i_dut (
    .i_mclk(clk), .i_reset_n(rst_n), .i_two_phase(two_ph), .i_output_enable(en),
    .i_nominal_ref(12'(NOM)), .i_feedback_input_0(fb0), .i_feedback_input_1(fb0),
    .i_cmd_valid(v), .i_cmd_write(w), .i_cmd_code(code), .i_cmd_page(pg_sel),
    .i_cmd_wdata(wd), .o_cmd_done(done), .o_cmd_ack(ack), .o_cmd_rdata(rd),
    .o_power_good_output(pg), .o_low_output_fault(uv), .o_high_output_fault(ov),
    .o_soft_start_go(go), .o_switching(sw), .o_monitor_converter_enable(mon_en),
    .o_first_channel_deadtime_extend(dt1), .o_second_channel_deadtime_extend(dt2),
    .o_nvm_store(nvm_st), .o_nvm_options(nvm_o));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic chk(input logic [16:0] got, input logic [16:0] exp, input string m);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk
  task automatic finish_test();
    chk(17'(exp_q.size()), 17'h0_0000, "answers missing");
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : finish_test
  task automatic cmd(input logic wr, input logic [7:0] c, input logic p, input logic [15:0] d,
                     input logic a, input logic [15:0] r);
    exp_q.push_back({a, r});
    i_host.send(wr, c, p, d);
    repeat (2) @(negedge clk);
  endtask : cmd
  always @(negedge clk) begin
    if (done === 1'b1) begin
      if (exp_q.size() == 0) chk(17'h0_0000, 17'h1_ffff, "unexpected answer");
      else chk({ack, rd}, exp_q.pop_front(), "command answer");
      chk(17'(nvm_st), 17'(w && code == CMD_STORE_ALL), "store pulse");
    end
  end
  task automatic seq(input int ch, input int n, input int m);
    int c;
    @(posedge clk);
    #1;
    en[ch] = 1'b1;
    c = 0;
    do begin @(negedge clk); c++; end while (go[ch] !== 1'b1 && c < 40);
    chk(17'(c), 17'(n * RAMP + 2), "on delay");
    chk(17'(sw[ch]), 17'h0_0001, "switching at go");
    if (c == 40) finish_test();
    @(posedge clk);
    #1;
    en[ch] = 1'b0;
    c = 0;
    do begin @(negedge clk); c++; end while (sw[ch] !== 1'b0 && c < 40);
    chk(17'(c), 17'(m * RAMP + 2), "off delay");
    if (c == 40) finish_test();
  endtask : seq
  task automatic win(input int s);
    int f[13];
    int lt, lr, ht, hr;
    logic [12:0] ep = 13'h1249;
    logic [12:0] eu = 13'h0030;
    logic [12:0] eo = 13'h0c00;
    lt = NOM * (10000 + LTRIP_PCT[s]) / 10000;
    lr = NOM * (10000 + LREL_PCT[s]) / 10000;
    ht = NOM * (10000 + HTRIP_PCT[s]) / 10000;
    hr = NOM * (10000 + HREL_PCT[s]) / 10000;
    f = '{NOM, lt, lr, lr + 1, NOM * (10000 + UV_PCT[s]) / 10000, lr, lr + 1, ht, hr, hr - 1,
          NOM * (10000 + OV_PCT[s]) / 10000, hr, hr - 1};
    for (int i = 0; i < 13; i++) begin
      @(posedge clk);
      #1;
      fb0 = 12'(f[i]);
      repeat (2) @(negedge clk);
      chk(17'({pg[0], uv[0], ov[0]}), 17'({ep[i], eu[i], eo[i]}),
          "window");
      chk(17'({pg[1], uv[1], ov[1]}), 17'({ep[i], eu[i], eo[i]}),
          "window second");
    end
  endtask : win
  initial begin
    seed = 32'h3bd6;
    errors = 0;
    tests_run = 0;
    {rst_n, two_ph, en, fb0} = {1'b0, 1'b0, 2'h0, 12'(NOM)};
    repeat (10) @(posedge clk);
    #1;
    rst_n = 1'b1;
    chk({mon_en, nvm_o}, 17'h0_000c, "reset outputs");
    cmd(0, CMD_OPTIONS, 0, 16'h0000, 1, OPT_RESET);
    cmd(0, CMD_ON_OFF_DLY, 0, 16'h0000, 1, 16'h0000);
    cmd(0, CMD_THRESH_SEL, 1, 16'h0000, 1, 16'h0000);
    cmd(1, CMD_IDENT, 0, 16'hffff, 0, 16'h0000);
    cmd(0, CMD_IDENT, 0, 16'h0000, 1, {ID, REV});
    cmd(0, 8'h00, 0, 16'h0000, 0, 16'h0000);
    cmd(0, CMD_STORE_ALL, 0, 16'h0000, 0, 16'h0000);
    k = $random(seed);
    cmd(1, CMD_OPTIONS, 0, 16'(k), 1, 16'h0000);
    cmd(0, CMD_OPTIONS, 0, 16'h0000, 1, {13'h000e, k[2:0]});
    chk({mon_en, dt2, dt1}, 17'(k[2:0]), "option outputs");
    cmd(1, CMD_STORE_ALL, 0, 16'h0000, 1, 16'h0000);
    chk(17'(nvm_o), 17'(k[2:0]), "stored options");
    $display("test registers done");
    cmd(1, CMD_ON_OFF_DLY, 0, 16'h00ff, 1, 16'h0000);
    cmd(0, CMD_ON_OFF_DLY, 0, 16'h0000, 1, 16'h00ee);
    seq(0, 7, 7);
    cmd(1, CMD_ON_OFF_DLY, 0, 16'h0022, 1, 16'h0000);
    seq(0, 1, 1);
    seq(1, 0, 0);
    $display("test sequencing done");
    @(posedge clk);
    #1;
    two_ph = 1'b1;
    cmd(1, CMD_ON_OFF_DLY, 1, 16'h00ee, 0, 16'h0000);
    cmd(1, CMD_THRESH_SEL, 1, 16'h0003, 0, 16'h0000);
    cmd(0, CMD_ON_OFF_DLY, 1, 16'h0000, 1, 16'h0000);
    cmd(0, CMD_THRESH_SEL, 1, 16'h0000, 1, 16'h0000);
    $display("test paging done");
    for (int s = 0; s < 4; s++) begin
      cmd(1, CMD_THRESH_SEL, 0, 16'(s), 1, 16'h0000);
      win(s);
    end
    $display("test windows done");
    finish_test();
  end
endmodule : power_good_output_sequence_option_regs_tb
`default_nettype wire
